// *** core/diag_regs_pkg.sv ***
/*
 * Package for the diagnostic status and mismatch register group.
 * Assumes an upstream I2C slave engine that presents byte-wide register
 * reads and writes as single-cycle strobes on the core clock.
 */
package diag_regs_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_DIAG_STATUS_TWO  = 8'h1d; // Second diagnostic byte
	localparam logic [7:0] ADDR_CURRENT_MISMATCH = 8'h1e; // Current mismatch flags
	localparam logic [7:0] ADDR_ON_TIME_MISMATCH = 8'h1f; // On-time mismatch flags
	localparam logic [7:0] ADDR_MISMATCH_DISABLE = 8'h20; // Mismatch check disable
	localparam logic [7:0] ADDR_BOOST_MONITOR    = 8'h21; // Boost monitor ADC result

	// Bit positions in the second diagnostic byte
	localparam int BIT_CORE_REG_OOR  = 7; // Core regulator out of range
	localparam int BIT_PACKET_ERR    = 6; // Packet check error
	localparam int BIT_SUPPLY_UV     = 5; // Supply input undervoltage
	localparam int BIT_CLOCK_ERR     = 4; // Clock error, read only
	localparam int BIT_GATE_RAIL_OOR = 3; // Gate drive rail out of range
	localparam int BIT_REF_DISAGREE  = 2; // Bandgap disagreement
	localparam int BIT_NVM_FAULT     = 1; // Nonvolatile memory fault, read only
	localparam int BIT_INPUT_OC      = 0; // Input overcurrent shutdown

	// Bits of the diagnostic byte cleared by a read
	localparam logic [7:0] DIAG_RC_MASK = 8'hed;

	// Bit positions in the disable register and in the second mask byte
	localparam int BIT_CURRENT_INHIBIT   = 7; // Current check inhibit
	localparam int BIT_GLOBAL_ON_INHIBIT = 6; // All on-time checks inhibited
	localparam int BIT_ON_TIME_GATE      = 7; // On-time mismatch fault gate
	localparam int BIT_PACKET_GATE       = 6; // Packet check fault gate
	localparam int BIT_SUPPLY_UV_GATE    = 5; // Supply undervoltage fault gate
	localparam int BIT_CURRENT_GATE      = 4; // Current mismatch fault gate

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00; // All registers here reset to zero

	// Clock stall time and its cycle count at 40 MHz
	localparam int CLK_PERIOD_PS    = 25000; // Core clock period
	localparam int CLK_STALL_NS     = 1000;  // Stall limit, 1 us
	localparam int CLK_STALL_CYCLES = (CLK_STALL_NS * 1000) / CLK_PERIOD_PS;

	// Number of LED channels
	localparam int NUM_CH = 6;

	// Register access strobe bundle from the I2C slave engine
	typedef struct packed {
		logic       rd;    // Read strobe, one cycle
		logic       wr;    // Write strobe, one cycle
		logic [7:0] addr;  // Register address
		logic [7:0] wdata; // Write data
	} reg_req_s;

	// Detector event inputs, one-cycle or level, sampled each cycle
	typedef struct packed {
		logic       coreRegOor;   // Core regulator out of range
		logic       packetErr;    // Packet check failed
		logic       supplyUv;     // Supply below low-voltage threshold
		logic       freqOor;      // Clock frequency out of range
		logic       gateRailOor;  // Gate drive rail out of range
		logic       refDisagree;  // Bandgap references disagree
		logic       nvmFault;     // Nonvolatile memory fault
		logic       senseOver;    // Sense voltage above 200 mV
	} diag_evt_s;

	// Clock activity detector state
	typedef enum logic [0:0] {
		CLK_OK    = 1'b0, // Oscillator seen toggling
		CLK_FAULT = 1'b1  // Error latched until power-on reset
	} clk_state_e;

endpackage : diag_regs_pkg

// *** core/diag_status_mismatch_regs.sv ***
/*
 * Diagnostic status and mismatch-check registers with fault output gating.
 * Holds the second diagnostic byte, the per-channel mismatch flags, the
 * mismatch check disable register and the boost monitor result, and
 * drives the open-drain fault pin enable and the shutdown requests.
 * Assumes detectors and the I2C slave run on core_clk, that rst is the
 * power-on reset, and that oscTick toggles from the monitored oscillator.
 * The second mask byte is owned elsewhere and arrives as a port.
 */
`timescale 1ns/10ps

module diag_status_mismatch_regs
#(
	parameter int STALL_CYCLES = diag_regs_pkg::CLK_STALL_CYCLES // Clock stall limit
)
(
	input  wire logic                      core_clk,         // Core clock, 40 MHz
	input  wire logic                      rst,              // Power-on reset, async high
	input  wire diag_regs_pkg::reg_req_s   regReq,           // Register access strobes
	output logic [7:0]                     regRdata,         // Read data, registered
	output logic                           regRvalid,        // Read data valid pulse
	input  wire diag_regs_pkg::diag_evt_s  diagEvt,          // Detector events
	input  wire logic                      oscTick,          // Toggle from oscillator
	input  wire logic [5:0]                curMismatchRaw,   // Per-channel current mismatch
	input  wire logic [5:0]                onTimeMismatchRaw,// Per-channel on-time mismatch
	input  wire logic [5:0]                chActive,         // Channels in use
	input  wire logic [7:0]                boostAdcData,     // Boost monitor conversion
	input  wire logic                      boostAdcValid,    // Conversion done pulse
	input  wire logic [7:0]                faultGateTwo,     // Second mask byte
	input  wire logic                      otherFaultLow,    // Faults from other groups
	input  wire logic                      overcurrentShutdownInhibit, // Sense shutdown off
	output logic                           fault_output_low_o, // Fault pin output value
	output logic                           fault_output_low_oe,// Fault pin drive enable
	output logic                           boostDisable,     // Stop the boost converter
	output logic                           deviceShutdown    // Halt device operation
);
	import diag_regs_pkg::*;

	// State registers and their next values
	logic [7:0]  diagFlags_ff,   nxt_diagFlags;   // Second diagnostic byte
	logic [5:0]  curMm_ff,       nxt_curMm;       // Current mismatch flags
	logic [5:0]  onMm_ff,        nxt_onMm;        // On-time mismatch flags
	logic [7:0]  mmDisable_ff,   nxt_mmDisable;   // Mismatch check disable
	logic [7:0]  boostAdc_ff,    nxt_boostAdc;    // Latest boost ADC result
	logic [7:0]  rdata_ff,       nxt_rdata;       // Read data
	logic        rvalid_ff,      nxt_rvalid;      // Read valid
	logic        tickPrev_ff,    nxt_tickPrev;    // Previous oscillator toggle
	logic [15:0] stallCnt_ff,    nxt_stallCnt;    // Cycles without toggle
	clk_state_e  clkState_ff,    nxt_clkState;    // Clock error state
	logic        gateOff_ff,     nxt_gateOff;     // Gate rail shutdown latch
	logic        nvmHalt_ff,     nxt_nvmHalt;     // Memory fault halt latch
	logic        faultLow_ff,    nxt_faultLow;    // Registered fault pin level

	// Decoded strobes and derived enables
	logic        rdDiag;    // Read of the diagnostic byte
	logic        rdCur;     // Read of the current mismatch byte
	logic [5:0]  onChecked; // Channels whose on-time check runs

	// Address match helper for read and write strobes
	function automatic logic hit(input logic strobe, input logic [7:0] a,
		input logic [7:0] target);
		hit = strobe && (a == target);
	endfunction : hit

	// Fault request that a set gate bit keeps off the pin
	function automatic logic gated(input logic flag, input logic gate);
		gated = flag && !gate;
	endfunction : gated

	// Read strobes that trigger a read clear
	assign rdDiag = hit(regReq.rd, regReq.addr, ADDR_DIAG_STATUS_TWO);
	assign rdCur  = hit(regReq.rd, regReq.addr, ADDR_CURRENT_MISMATCH);

	// Enabled on-time checks: global and per-channel inhibits, active only
	assign onChecked = chActive & ~mmDisable_ff[5:0]
		& {NUM_CH{~mmDisable_ff[BIT_GLOBAL_ON_INHIBIT]}};

	// Clock activity watch: stall counter and error state
	always_comb
	begin
		nxt_tickPrev = oscTick;
		nxt_stallCnt = stallCnt_ff;
		nxt_clkState = clkState_ff;
		// Count cycles since the last oscillator edge, saturating
		if (oscTick != tickPrev_ff)
			nxt_stallCnt = '0; // Toggle seen, restart count
		else if (stallCnt_ff < 16'(STALL_CYCLES))
			nxt_stallCnt = stallCnt_ff + 16'h0001;
		// Stall limit reached or frequency detector fired
		if ((stallCnt_ff >= 16'(STALL_CYCLES)) || diagEvt.freqOor)
			nxt_clkState = CLK_FAULT;
		// No path back to CLK_OK: only reset leaves the fault state
		unique case (clkState_ff)
			CLK_OK:    ;
			CLK_FAULT: nxt_clkState = CLK_FAULT;
		endcase
	end

	// Flag registers: hardware set wins over read clear
	always_comb
	begin
		nxt_diagFlags = diagFlags_ff;
		nxt_curMm     = curMm_ff;
		nxt_onMm      = onMm_ff;
		// Read clears first so that a set below overrides it
		if (rdDiag)
			nxt_diagFlags = diagFlags_ff & ~DIAG_RC_MASK;
		if (rdCur)
			nxt_curMm = '0;
		// Hardware events set their flags
		if (diagEvt.coreRegOor)
			nxt_diagFlags[BIT_CORE_REG_OOR] = 1'b1;
		if (diagEvt.packetErr)
			nxt_diagFlags[BIT_PACKET_ERR] = 1'b1;
		if (diagEvt.supplyUv)
			nxt_diagFlags[BIT_SUPPLY_UV] = 1'b1;
		// Clock error mirrors the latched state, so reads cannot clear it
		nxt_diagFlags[BIT_CLOCK_ERR] = (clkState_ff == CLK_FAULT);
		if (diagEvt.gateRailOor)
			nxt_diagFlags[BIT_GATE_RAIL_OOR] = 1'b1;
		if (diagEvt.refDisagree)
			nxt_diagFlags[BIT_REF_DISAGREE] = 1'b1;
		// Memory fault is sticky and ignores reads
		nxt_diagFlags[BIT_NVM_FAULT] = diagFlags_ff[BIT_NVM_FAULT] | diagEvt.nvmFault;
		if (diagEvt.senseOver)
			nxt_diagFlags[BIT_INPUT_OC] = 1'b1;
		// Current check runs only when not inhibited
		if (!mmDisable_ff[BIT_CURRENT_INHIBIT])
			nxt_curMm = nxt_curMm | curMismatchRaw;
		// On-time flags follow the live checks, unaffected by reads
		nxt_onMm = onTimeMismatchRaw & onChecked;
	end

	// Writable disable register and ADC capture
	always_comb
	begin
		nxt_mmDisable = mmDisable_ff;
		nxt_boostAdc  = boostAdc_ff;
		// Only this address is writable; other writes are ignored
		if (hit(regReq.wr, regReq.addr, ADDR_MISMATCH_DISABLE))
			nxt_mmDisable = regReq.wdata;
		// Keep the last conversion until a new one completes
		if (boostAdcValid)
			nxt_boostAdc = boostAdcData;
	end

	// Read multiplexer: returns values before the clear takes effect
	always_comb
	begin
		// Valid follows any read, mapped or not
		nxt_rvalid = regReq.rd;
		nxt_rdata  = rdata_ff;
		if (regReq.rd)
		begin
			unique case (regReq.addr)
				ADDR_DIAG_STATUS_TWO:  nxt_rdata = diagFlags_ff;
				ADDR_CURRENT_MISMATCH: nxt_rdata = {2'b00, curMm_ff};
				ADDR_ON_TIME_MISMATCH: nxt_rdata = {2'b00, onMm_ff};
				ADDR_MISMATCH_DISABLE: nxt_rdata = mmDisable_ff;
				ADDR_BOOST_MONITOR:    nxt_rdata = boostAdc_ff;
				default:               nxt_rdata = RST_BYTE; // Not in this group
			endcase
		end
	end

	// Shutdown latches and fault pin level
	always_comb
	begin
		// Shutdown causes latch until power-on reset
		nxt_gateOff = gateOff_ff | diagEvt.gateRailOor;
		nxt_nvmHalt = nvmHalt_ff | diagEvt.nvmFault;
		// Any unmasked fault request pulls the pin low one cycle later
		nxt_faultLow = otherFaultLow
			| (clkState_ff == CLK_FAULT)
			| diagFlags_ff[BIT_NVM_FAULT]
			| gated(diagFlags_ff[BIT_PACKET_ERR], faultGateTwo[BIT_PACKET_GATE])
			| gated(diagFlags_ff[BIT_SUPPLY_UV], faultGateTwo[BIT_SUPPLY_UV_GATE])
			| gated(|curMm_ff, faultGateTwo[BIT_CURRENT_GATE])
			| gated(|onMm_ff, faultGateTwo[BIT_ON_TIME_GATE]);
	end

	// Clock watch registers; the error state leaves only on reset
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			// Power-on reset: oscillator assumed healthy
			tickPrev_ff  <= 1'b0;
			stallCnt_ff  <= 16'h0000;
			clkState_ff  <= CLK_OK;
		end
		else
		begin
			// Follow the oscillator and the stall count
			tickPrev_ff  <= nxt_tickPrev;
			stallCnt_ff  <= nxt_stallCnt;
			clkState_ff  <= nxt_clkState;
		end
	end

	// Flag registers of the three status bytes
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			// All flags clear after power-on reset
			diagFlags_ff <= RST_BYTE;
			curMm_ff     <= 6'h00;
			onMm_ff      <= 6'h00;
		end
		else
		begin
			// Sets and read clears resolved in the next-value logic
			diagFlags_ff <= nxt_diagFlags;
			curMm_ff     <= nxt_curMm;
			onMm_ff      <= nxt_onMm;
		end
	end

	// Disable register and boost monitor result
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			// Checks enabled and no conversion seen
			mmDisable_ff <= RST_BYTE;
			boostAdc_ff  <= RST_BYTE;
		end
		else
		begin
			// Host writes and ADC captures
			mmDisable_ff <= nxt_mmDisable;
			boostAdc_ff  <= nxt_boostAdc;
		end
	end

	// Read answer registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			// No answer pending
			rdata_ff     <= RST_BYTE;
			rvalid_ff    <= 1'b0;
		end
		else
		begin
			// Answer one cycle after the read strobe
			rdata_ff     <= nxt_rdata;
			rvalid_ff    <= nxt_rvalid;
		end
	end

	// Shutdown latches and fault pin register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			// Device free to run, pin released
			gateOff_ff   <= 1'b0;
			nvmHalt_ff   <= 1'b0;
			faultLow_ff  <= 1'b0;
		end
		else
		begin
			// Latches stick, pin level follows its requests
			gateOff_ff   <= nxt_gateOff;
			nvmHalt_ff   <= nxt_nvmHalt;
			faultLow_ff  <= nxt_faultLow;
		end
	end

	// Outputs
	assign regRdata            = rdata_ff;
	assign regRvalid           = rvalid_ff;
	assign fault_output_low_o  = 1'b0; // Open drain: only ever pulls low
	assign fault_output_low_oe = faultLow_ff;
	// Boost stops on uninhibited overcurrent or any shutdown
	assign boostDisable = (diagFlags_ff[BIT_INPUT_OC] & ~overcurrentShutdownInhibit)
		| gateOff_ff | nvmHalt_ff;
	assign deviceShutdown = gateOff_ff | nvmHalt_ff;

endmodule : diag_status_mismatch_regs

// *** tb/diag_regs_checker.sv ***
/* Assertions for the diagnostic register group.
   Bound to the group; sees only its ports and shares its clock and reset. */
`timescale 1ns/10ps
module diag_regs_checker
	import diag_regs_pkg::*;
#(
	parameter int STALL_CYCLES = 40 // Clock stall limit
)
(
	input wire logic	core_clk,	// Core clock
	input wire logic	rst,	// Power-on reset
	input wire diag_regs_pkg::reg_req_s	regReq,	// Register strobes
	input wire logic [7:0]	regRdata,	// Read data
	input wire logic	regRvalid,	// Read valid
	input wire diag_regs_pkg::diag_evt_s	diagEvt,	// Detector events
	input wire logic	oscTick,	// Oscillator toggle
	input wire logic	overcurrentShutdownInhibit,	// Sense stop off
	input wire logic	fault_output_low_o,	// Pin value
	input wire logic	fault_output_low_oe,	// Pin drive
	input wire logic	boostDisable,	// Boost stop
	input wire logic	deviceShutdown	// Device halt
);
	logic	oscPrev_ff;	// Last oscillator level
	logic [7:0]	stallCnt_ff;	// Cycles without a toggle
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Saturating count of cycles since the oscillator last moved
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			oscPrev_ff <= 1'b0;
			stallCnt_ff <= 8'h00;
		end
		else
		begin
			oscPrev_ff <= oscTick;
			stallCnt_ff <= (oscTick != oscPrev_ff) ? 8'h00
				: stallCnt_ff + 8'(stallCnt_ff != 8'hff);
		end
	end
	rvalid_pulse_a: assert property (regReq.rd |=> regRvalid)
		else $error("read not answered");
	rvalid_quiet_a: assert property (!regReq.rd |=> !regRvalid)
		else $error("answer without read");
	rdata_hold_a: assert property (!regReq.rd |=> $stable(regRdata))
		else $error("read data moved without read");
	pin_value_a: assert property (!fault_output_low_o)
		else $error("fault pin driven high");
	stall_fault_a: assert property (stallCnt_ff == 8'(STALL_CYCLES + 1)
		|-> ##[1:6] fault_output_low_oe)
		else $error("stalled clock not flagged on pin");
	shutdown_hold_a: assert property (deviceShutdown |=> deviceShutdown)
		else $error("shutdown released without reset");
	nvm_fault_a: assert property (diagEvt.nvmFault
		|-> ##2 (fault_output_low_oe && deviceShutdown))
		else $error("memory fault not acted on");
	rail_shut_a: assert property (diagEvt.gateRailOor |=> ##[0:1] deviceShutdown)
		else $error("gate rail fault did not shut down");
	sense_boost_a: assert property (diagEvt.senseOver && !overcurrentShutdownInhibit
		|-> ##[1:2] boostDisable)
		else $error("overcurrent did not stop boost");
endmodule : diag_regs_checker

bind diag_status_mismatch_regs diag_regs_checker #(.STALL_CYCLES(STALL_CYCLES)) CHK (
	.core_clk, .rst, .regReq, .regRdata, .regRvalid, .diagEvt, .oscTick,
	.overcurrentShutdownInhibit, .fault_output_low_o, .fault_output_low_oe,
	.boostDisable, .deviceShutdown);

// *** tb/diag_host_model.sv ***
/* Host side model issuing register reads and writes on the strobe bundle.
   Assumes the core clock of the register group; one request per task call. */
`timescale 1ns/10ps
module diag_host_model
	import diag_regs_pkg::*;
(
	input wire logic	core_clk,	// Core clock
	input wire logic [7:0]	regRdata,	// Read data
	input wire logic	regRvalid,	// Read valid
	input wire logic	faultLowOe,	// Fault pin pulled low
	output diag_regs_pkg::reg_req_s	regReq,	// Register strobes
	output logic	hostEnable	// Device enable pin
);
	initial regReq = '0;
	// Host drops the enable while the fault pin is low
	assign hostEnable = !faultLowOe;
	// One write strobe; idle fields are inverted so stale values never pass
	task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
	begin
		@(posedge core_clk) #1;
		regReq = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
		@(posedge core_clk) #1;
		regReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
	end
	endtask : regWrite
	// One read strobe; data is taken in the cycle that valid stands
	task automatic regRead(input logic [7:0] addr, output logic [7:0] data);
	begin
		@(posedge core_clk) #1;
		regReq = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
		@(posedge core_clk) #1;
		regReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hff};
		data = regRvalid ? regRdata : 8'hxx;
	end
	endtask : regRead
endmodule : diag_host_model

// *** tb/testbench.sv ***
/* Self-checking bench for the diagnostic register group.
   Assumes the host model for register access and a 40 MHz core clock. */
`timescale 1ns/10ps
module testbench;
	import diag_regs_pkg::*;
	typedef struct packed { logic [7:0] evt; logic [7:0] exp1; logic [7:0] exp2; } row_s;
	logic core_clk = 0, rst = 1, oscTick = 0, oscRun = 1, regRvalid, boostAdcValid = 0;
	logic inhibit = 0, faultO, faultOe, boostDisable, deviceShutdown, hostEnable;
	logic [7:0] regRdata, boostAdcData = 8'h00, faultGateTwo = 8'h00;
	logic [5:0] curRaw = 0, onRaw = 0, chActive = 0;
	reg_req_s regReq;
	diag_evt_s diagEvt = '0;
	int n_fail = 0, checks = 0, cycles = 0;
	// Event byte, first read, second read
	row_s rows [8] = '{
		'{8'h80, 8'h80, 8'h00},
		'{8'h40, 8'h40, 8'h00},
		'{8'h20, 8'h20, 8'h00},
		'{8'h08, 8'h08, 8'h00},
		'{8'h04, 8'h04, 8'h00},
		'{8'h01, 8'h01, 8'h00},
		'{8'h10, 8'h10, 8'h10},
		'{8'h02, 8'h12, 8'h12}};
	always #12.5 core_clk = ~core_clk;
	// Oscillator toggle changes just after the edge, like all stimulus
	always @(posedge core_clk) if (oscRun) oscTick <= #1 ~oscTick;
	diag_status_mismatch_regs DUT (.core_clk, .rst, .regReq, .regRdata, .regRvalid,
		.diagEvt, .oscTick, .curMismatchRaw(curRaw), .onTimeMismatchRaw(onRaw),
		.chActive, .boostAdcData, .boostAdcValid, .faultGateTwo, .otherFaultLow(1'b0),
		.overcurrentShutdownInhibit(inhibit), .fault_output_low_o(faultO),
		.fault_output_low_oe(faultOe), .boostDisable, .deviceShutdown);
	diag_host_model HOST (.core_clk, .regRdata, .regRvalid, .faultLowOe(faultOe),
		.regReq, .hostEnable);
	task automatic give_verdict();
	begin
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask : give_verdict
	// Hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	end
	endtask : check
	task automatic rdChk(input string what, input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
	begin
		HOST.regRead(addr, d);
		check(what, exp, d);
	end
	endtask : rdChk
	task automatic tick(input int n);
	begin
		repeat (n) @(posedge core_clk);
		#1;
	end
	endtask : tick
	task automatic doReset();
	begin
		rst = 1;
		tick(10);
		rst = 0;
	end
	endtask : doReset
	initial
	begin
		doReset();
		for (int a = 8'h1d; a <= 8'h22; a++) rdChk("reset value", 8'(a), 8'h00);
		HOST.regWrite(ADDR_MISMATCH_DISABLE, 8'ha5);
		rdChk("disable rw", ADDR_MISMATCH_DISABLE, 8'ha5);
		HOST.regWrite(ADDR_BOOST_MONITOR, 8'h77);
		HOST.regWrite(ADDR_DIAG_STATUS_TWO, 8'hff);
		HOST.regWrite(ADDR_MISMATCH_DISABLE, 8'h00);
		rdChk("adc read only", ADDR_BOOST_MONITOR, 8'h00);
		rdChk("diag read only", ADDR_DIAG_STATUS_TWO, 8'h00);
		$display("test registers done");
		foreach (rows[i])
		begin
			diagEvt = rows[i].evt;
			tick(1);
			diagEvt = '0;
			tick(2);
			rdChk("diag first read", ADDR_DIAG_STATUS_TWO, rows[i].exp1);
			rdChk("diag second read", ADDR_DIAG_STATUS_TWO, rows[i].exp2);
		end
		check("shutdown", 8'h01, {7'h00, deviceShutdown});
		$display("test rows done");
		doReset();
		inhibit = 1;
		diagEvt = 8'h01;
		tick(1);
		diagEvt = '0;
		tick(2);
		check("boost stop inhibited", 8'h00, {7'h00, boostDisable});
		rdChk("sense flag", ADDR_DIAG_STATUS_TWO, 8'h01);
		inhibit = 0;
		curRaw = 6'h15;
		tick(1);
		curRaw = 0;
		rdChk("current flags", ADDR_CURRENT_MISMATCH, 8'h15);
		rdChk("current cleared", ADDR_CURRENT_MISMATCH, 8'h00);
		HOST.regWrite(ADDR_MISMATCH_DISABLE, 8'h85);
		curRaw = 6'h3f;
		chActive = 6'h37;
		onRaw = 6'h3f;
		tick(2);
		curRaw = 0;
		rdChk("current inhibited", ADDR_CURRENT_MISMATCH, 8'h00);
		rdChk("on-time flags", ADDR_ON_TIME_MISMATCH, 8'h32);
		rdChk("on-time kept", ADDR_ON_TIME_MISMATCH, 8'h32);
		HOST.regWrite(ADDR_MISMATCH_DISABLE, 8'h40);
		rdChk("on-time all off", ADDR_ON_TIME_MISMATCH, 8'h00);
		boostAdcData = 8'h5c;
		boostAdcValid = 1;
		tick(1);
		boostAdcValid = 0;
		boostAdcData = 8'ha3;
		rdChk("adc result", ADDR_BOOST_MONITOR, 8'h5c);
		$display("test mismatch done");
		HOST.regWrite(ADDR_MISMATCH_DISABLE, 8'h00);
		faultGateTwo = 8'hf0;
		diagEvt = 8'h60;
		curRaw = 6'h3f;
		tick(1);
		diagEvt = '0;
		curRaw = 0;
		tick(3);
		check("masked pin", 8'h00, {7'h00, faultOe});
		onRaw = 0;
		rdChk("masked diag", ADDR_DIAG_STATUS_TWO, 8'h60);
		rdChk("masked current", ADDR_CURRENT_MISMATCH, 8'h3f);
		faultGateTwo = 8'h00;
		diagEvt = 8'h20;
		tick(1);
		diagEvt = '0;
		tick(3);
		check("unmasked pin", 8'h01, {7'h00, faultOe});
		rdChk("unmasked diag", ADDR_DIAG_STATUS_TWO, 8'h20);
		tick(3);
		check("pin after clear", 8'h00, {7'h00, faultOe});
		$display("test masks done");
		oscRun = 0;
		tick(50);
		rdChk("clock stall", ADDR_DIAG_STATUS_TWO, 8'h10);
		check("clock fault pin", 8'h01, {7'h00, faultOe});
		check("host enable", 8'h00, {7'h00, hostEnable});
		oscRun = 1;
		rdChk("clock sticky", ADDR_DIAG_STATUS_TWO, 8'h10);
		doReset();
		rdChk("clock after reset", ADDR_DIAG_STATUS_TWO, 8'h00);
		$display("test clock done");
		give_verdict();
	end
endmodule : testbench
